// file: verilog/two_wire_master_pkg.sv
package two_wire_master_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CTRL_GLOBAL  = 8'h00;
  localparam logic [7:0] ADDR_DEBUG        = 8'h02;
  localparam logic [7:0] ADDR_CTRL_PRIMARY = 8'h03;
  localparam logic [7:0] ADDR_CTRL_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_STATUS       = 8'h05;
  localparam logic [7:0] ADDR_TARGET       = 8'h07;
  localparam logic [7:0] ADDR_BYTE         = 8'h08;
  // field positions
  localparam int FAST_PLUS_BIT  = 1;
  localparam int RUN_DBG_BIT    = 0;
  localparam int READ_IE_BIT    = 7;
  localparam int WRITE_IE_BIT   = 6;
  localparam int QUICK_BIT      = 4;
  localparam int TMO_LSB        = 2;
  localparam int AUTO_ACK_BIT   = 1;
  localparam int ENABLE_BIT     = 0;
  localparam int FLUSH_BIT      = 3;
  localparam int ACK_CHOICE_BIT = 2;
  localparam int READ_FLAG_BIT  = 7;
  localparam int WRITE_FLAG_BIT = 6;
  localparam int HOLD_BIT       = 5;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // commands
  localparam logic [1:0] CMD_NONE      = 2'h0;
  localparam logic [1:0] CMD_RESTART   = 2'h1;
  localparam logic [1:0] CMD_BYTE_MOVE = 2'h2;
  localparam logic [1:0] CMD_STOP      = 2'h3;
  // timeout codes
  localparam logic [1:0] TMO_OFF  = 2'h0;
  localparam logic [1:0] TMO_SHORT = 2'h1;
  localparam logic [1:0] TMO_MID  = 2'h2;
  // timing
  localparam int CLK_MHZ    = 50;
  localparam int TMO_50_US  = 50;
  localparam int TMO_100_US = 100;
  localparam int TMO_200_US = 200;
  localparam int TMO_W      = 16;
  // bus line state
  typedef enum logic [1:0] {
    LINE_UNKNOWN = 2'b00,
    LINE_IDLE    = 2'b01,
    LINE_OWNER   = 2'b10,
    LINE_BUSY    = 2'b11
  } line_state_e;
endpackage : two_wire_master_pkg

// file: verilog/two_wire_master_control.sv
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module two_wire_master_control
  import two_wire_master_pkg::*;
#(
  parameter int unsigned TMO_50_CYC  = TMO_50_US * CLK_MHZ,   // short timeout count
  parameter int unsigned TMO_100_CYC = TMO_100_US * CLK_MHZ,  // mid timeout count
  parameter int unsigned TMO_200_CYC = TMO_200_US * CLK_MHZ   // long timeout count
)
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // processor debug state
  input  wire logic       debug_halt_i,
  // serial bus lines, sampled only
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  // byte engine events
  input  wire logic       engine_owns_i,
  input  wire logic       addr_ack_i,
  input  wire logic       dir_read_n_i,
  input  wire logic       byte_read_done_i,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       byte_write_done_i,
  input  wire logic       scl_hold_set_i,
  // byte engine controls
  output logic            master_enable_o,
  output logic            fast_plus_o,
  output logic            halt_o,
  output logic            flush_o,
  output logic            addr_go_o,
  output logic            byte_go_o,
  output logic            ack_go_o,
  output logic            ack_nack_o,
  output logic            op_restart_o,
  output logic            op_read_o,
  output logic            op_send_o,
  output logic            op_stop_o,
  output logic            scl_release_o,
  output logic      [7:0] target_o,
  output logic      [7:0] byte_o,
  // interrupt requests
  output logic            read_irq_o,
  output logic            write_irq_o
);

  // whole block state in one record
  typedef struct packed {
    logic              fast_plus_select;   // speed class
    logic              run_in_debug_halt;  // keep going under break
    logic              read_irq_enable;
    logic              write_irq_enable;
    logic              quick_cmd_enable;
    logic [1:0]        timeout_sel;        // supervisor select
    logic              auto_ack_enable;
    logic              enable;
    logic              ack_choice;         // 0 ack, 1 nack
    logic              read_done_flag;
    logic              write_done_flag;
    logic              scl_held_low;
    line_state_e       line_state;
    logic [7:0]        master_target_reg;
    logic [7:0]        master_byte_reg;
    logic [7:0]        rdata;              // read answer
    logic              scl_s1;             // synchroniser stages
    logic              scl_s2;
    logic              sda_s1;
    logic              sda_s2;
    logic              scl_d;              // last synced levels
    logic              sda_d;
    logic [TMO_W-1:0]  idle_cnt;           // inactivity counter
    logic              flush;
    logic              addr_go;
    logic              byte_go;
    logic              ack_go;
    logic              ack_nack;
    logic              op_restart;
    logic              op_read;
    logic              op_send;
    logic              op_stop;
    logic              scl_release;
  } state_s;

  state_s st;       // registered state
  state_s next_st;  // next state

  logic             halted;      // frozen by debug break
  logic             active;      // enabled and not frozen
  logic             line_edge;   // any change on synced lines
  logic             start_seen;
  logic             stop_seen;
  logic [TMO_W-1:0] tmo_limit;   // selected inactivity limit
  logic [1:0]       cmd;         // command field of this write

  // freeze and edge detection; only the second stage is read
  always_comb
  begin
    halted     = debug_halt_i && !st.run_in_debug_halt;
    active     = st.enable && !halted;
    line_edge  = (st.scl_s2 != st.scl_d) || (st.sda_s2 != st.sda_d);
    start_seen = st.scl_s2 && st.scl_d && st.sda_d && !st.sda_s2;
    stop_seen  = st.scl_s2 && st.scl_d && !st.sda_d && st.sda_s2;
    cmd        = wdata_i[1:0];
  end

  // timeout limit, all figures assume a 50 MHz core clock
  always_comb
  begin
    case (st.timeout_sel)
      TMO_OFF:   tmo_limit = '0;
      TMO_SHORT: tmo_limit = TMO_W'(TMO_50_CYC);
      TMO_MID:   tmo_limit = TMO_W'(TMO_100_CYC);
      default:   tmo_limit = TMO_W'(TMO_200_CYC);
    endcase
  end

  // next state
  always_comb
  begin
    next_st = st;
    // pulses last one cycle only
    next_st.flush       = 1'b0;
    next_st.addr_go     = 1'b0;
    next_st.byte_go     = 1'b0;
    next_st.ack_go      = 1'b0;
    next_st.op_restart  = 1'b0;
    next_st.op_read     = 1'b0;
    next_st.op_send     = 1'b0;
    next_st.op_stop     = 1'b0;
    next_st.scl_release = 1'b0;
    // two flip-flops on each pin before use
    next_st.scl_s1 = scl_i;
    next_st.scl_s2 = st.scl_s1;
    next_st.sda_s1 = sda_i;
    next_st.sda_s2 = st.sda_s1;
    next_st.scl_d  = st.scl_s2;
    next_st.sda_d  = st.sda_s2;

    // bus line tracking keeps running under a break
    if (start_seen)
      next_st.line_state = engine_owns_i ? LINE_OWNER : LINE_BUSY;
    else if (stop_seen)
      next_st.line_state = LINE_IDLE;

    // inactivity supervisor, frozen under a break
    if (line_edge || tmo_limit == '0 || st.line_state == LINE_IDLE)
      next_st.idle_cnt = '0;
    else if (!halted)
    begin
      if (st.idle_cnt >= tmo_limit - TMO_W'(1))
      begin
        next_st.idle_cnt   = '0;
        next_st.line_state = LINE_IDLE;
      end
      else
        next_st.idle_cnt = st.idle_cnt + TMO_W'(1);
    end

    // register reads, answer stands the next cycle
    if (rd_i)
    begin
      case (addr_i)
        ADDR_CTRL_GLOBAL:  next_st.rdata = {6'h00, st.fast_plus_select, 1'b0};
        ADDR_DEBUG:        next_st.rdata = {7'h00, st.run_in_debug_halt};
        ADDR_CTRL_PRIMARY: next_st.rdata = {st.read_irq_enable, st.write_irq_enable, 1'b0,
                                            st.quick_cmd_enable, st.timeout_sel,
                                            st.auto_ack_enable, st.enable};
        ADDR_CTRL_COMMAND: next_st.rdata = {5'h00, st.ack_choice, 2'b00};
        ADDR_STATUS:       next_st.rdata = {st.read_done_flag, st.write_done_flag,
                                            st.scl_held_low, 3'b000, st.line_state};
        ADDR_TARGET:       next_st.rdata = st.master_target_reg;
        ADDR_BYTE:         next_st.rdata = st.master_byte_reg;
        default:           next_st.rdata = RESET_BYTE;
      endcase
      // reading the byte clears the hold flag and may ack
      if (addr_i == ADDR_BYTE && active)
      begin
        next_st.read_done_flag  = 1'b0;
        next_st.write_done_flag = 1'b0;
        next_st.scl_held_low    = 1'b0;
        if (st.auto_ack_enable)
        begin
          next_st.ack_go   = 1'b1;
          next_st.ack_nack = st.ack_choice;
        end
      end
    end

    // register writes
    if (wr_i)
    begin
      case (addr_i)
        ADDR_CTRL_GLOBAL: next_st.fast_plus_select = wdata_i[FAST_PLUS_BIT];
        ADDR_DEBUG:       next_st.run_in_debug_halt = wdata_i[RUN_DBG_BIT];
        ADDR_CTRL_PRIMARY:
        begin
          next_st.read_irq_enable  = wdata_i[READ_IE_BIT];
          next_st.write_irq_enable = wdata_i[WRITE_IE_BIT];
          next_st.quick_cmd_enable = wdata_i[QUICK_BIT];
          next_st.timeout_sel      = wdata_i[TMO_LSB+1:TMO_LSB];
          next_st.auto_ack_enable  = wdata_i[AUTO_ACK_BIT];
          next_st.enable           = wdata_i[ENABLE_BIT];
        end
        ADDR_CTRL_COMMAND:
        begin
          next_st.ack_choice = wdata_i[ACK_CHOICE_BIT];
          // new ack choice applies to the command in the same write
          if (active && cmd != CMD_NONE)
          begin
            next_st.scl_held_low    = 1'b0;
            next_st.scl_release     = 1'b1;
            next_st.read_done_flag  = 1'b0;
            next_st.write_done_flag = 1'b0;
            next_st.ack_nack        = wdata_i[ACK_CHOICE_BIT];
            // a sender has no ack to give
            next_st.ack_go = !(cmd == CMD_BYTE_MOVE && !dir_read_n_i);
            case (cmd)
              CMD_RESTART:   next_st.op_restart = 1'b1;
              CMD_BYTE_MOVE:
              begin
                next_st.op_read = dir_read_n_i;
                next_st.op_send = !dir_read_n_i;
              end
              default:       next_st.op_stop = 1'b1;
            endcase
          end
        end
        ADDR_STATUS:
        begin
          // write one to clear, 1 in state field forces idle
          if (wdata_i[READ_FLAG_BIT])
            next_st.read_done_flag = 1'b0;
          if (wdata_i[WRITE_FLAG_BIT])
            next_st.write_done_flag = 1'b0;
          if (wdata_i[HOLD_BIT])
            next_st.scl_held_low = 1'b0;
          if (wdata_i[1:0] == LINE_IDLE && st.enable)
            next_st.line_state = LINE_IDLE;
        end
        ADDR_TARGET:
        begin
          next_st.master_target_reg = wdata_i;
          next_st.read_done_flag    = 1'b0;
          next_st.write_done_flag   = 1'b0;
          next_st.scl_held_low      = 1'b0;
          // unknown bus: terminate at once with write flag
          if (st.line_state == LINE_UNKNOWN)
            next_st.write_done_flag = st.enable;
          else
            next_st.addr_go = active;
        end
        ADDR_BYTE:
        begin
          // loading before the target sends stale data
          next_st.master_byte_reg = wdata_i;
          next_st.read_done_flag  = 1'b0;
          next_st.write_done_flag = 1'b0;
          next_st.scl_held_low    = 1'b0;
          next_st.byte_go         = active;
        end
        default: ;  // unmapped writes ignored
      endcase
    end

    // engine events come after access clears so a set wins; a flush still clears
    if (active)
    begin
      if (addr_ack_i && st.quick_cmd_enable)
      begin
        // no data byte; software must stop or restart next
        if (dir_read_n_i)
          next_st.read_done_flag = 1'b1;
        else
          next_st.write_done_flag = 1'b1;
      end
      if (byte_read_done_i)
      begin
        next_st.master_byte_reg = rx_byte_i;
        next_st.read_done_flag  = 1'b1;
      end
      if (byte_write_done_i)
        next_st.write_done_flag = 1'b1;
      if (scl_hold_set_i)
        next_st.scl_held_low = 1'b1;
    end

    // flush overrides flags, both data registers, line state and op strobes, but not scl_release
    if (wr_i && addr_i == ADDR_CTRL_COMMAND && wdata_i[FLUSH_BIT])
    begin
      next_st.flush             = 1'b1;
      next_st.master_target_reg = RESET_BYTE;
      next_st.master_byte_reg   = RESET_BYTE;
      next_st.read_done_flag    = 1'b0;
      next_st.write_done_flag   = 1'b0;
      next_st.scl_held_low      = 1'b0;
      next_st.line_state        = LINE_UNKNOWN;
      next_st.ack_go            = 1'b0;
      next_st.op_restart        = 1'b0;
      next_st.op_read           = 1'b0;
      next_st.op_send           = 1'b0;
      next_st.op_stop           = 1'b0;
    end

    // disabled master knows nothing of the bus
    if (!next_st.enable)
      next_st.line_state = LINE_UNKNOWN;
  end

  // state register; lines rest high after reset
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st            <= '0;
      st.scl_s1     <= 1'b1;
      st.scl_s2     <= 1'b1;
      st.sda_s1     <= 1'b1;
      st.sda_s2     <= 1'b1;
      st.scl_d      <= 1'b1;
      st.sda_d      <= 1'b1;
      st.line_state <= LINE_UNKNOWN;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs
  assign rdata_o         = st.rdata;
  assign master_enable_o = st.enable;
  assign fast_plus_o     = st.fast_plus_select;
  assign halt_o          = halted;
  assign flush_o         = st.flush;
  assign addr_go_o       = st.addr_go;
  assign byte_go_o       = st.byte_go;
  assign ack_go_o        = st.ack_go;
  assign ack_nack_o      = st.ack_nack;
  assign op_restart_o    = st.op_restart;
  assign op_read_o       = st.op_read;
  assign op_send_o       = st.op_send;
  assign op_stop_o       = st.op_stop;
  assign scl_release_o   = st.scl_release;
  assign target_o        = st.master_target_reg;
  assign byte_o          = st.master_byte_reg;
  // global enable gating happens in the interrupt controller
  assign read_irq_o      = st.read_irq_enable && st.read_done_flag;
  assign write_irq_o     = st.write_irq_enable && st.write_done_flag;

endmodule : two_wire_master_control
`default_nettype wire

// file: verification/two_wire_master_chk.sv
`timescale 1ns/10ps
`default_nettype none
// watches the control block from its ports only
module two_wire_master_chk
  import two_wire_master_pkg::*;
(
  // clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // debug and engine inputs
  input wire logic       debug_halt_i,
  input wire logic       dir_read_n_i,
  input wire logic       byte_read_done_i,
  // engine controls and requests
  input wire logic       master_enable_o,
  input wire logic       fast_plus_o,
  input wire logic       halt_o,
  input wire logic       flush_o,
  input wire logic       ack_go_o,
  input wire logic       ack_nack_o,
  input wire logic       op_restart_o,
  input wire logic       op_read_o,
  input wire logic       op_send_o,
  input wire logic       op_stop_o,
  input wire logic       scl_release_o,
  input wire logic       read_irq_o,
  input wire logic       write_irq_o
);
  logic [7:0] ctl_sh;  // shadow of primary control writes
  logic       dbg_sh;  // shadow of run-in-halt bit
  logic       go;      // block may act this cycle

  // shadows of software writes; flush leaves both registers alone
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ctl_sh <= 8'h00;
      dbg_sh <= 1'b0;
    end
    else if (wr_i && addr_i == ADDR_CTRL_PRIMARY)
      ctl_sh <= wdata_i;
    else if (wr_i && addr_i == ADDR_DEBUG)
      dbg_sh <= wdata_i[RUN_DBG_BIT];
  end
  assign go = master_enable_o && !halt_o;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // a command write that the block must act on
  sequence s_cmd(logic [1:0] c);
    wr_i && addr_i == ADDR_CTRL_COMMAND && wdata_i[1:0] == c && go;
  endsequence

  stop_cmd_a :
  assert property (s_cmd(CMD_STOP) |=> op_stop_o && ack_go_o && scl_release_o && ack_nack_o == $past(wdata_i[2]))
    else $error("stop not carried out");
  restart_cmd_a :
  assert property (s_cmd(CMD_RESTART) |=> op_restart_o && ack_go_o && !op_stop_o)
    else $error("restart not carried out");
  byte_move_a :
  assert property (s_cmd(CMD_BYTE_MOVE) |=> op_read_o == $past(dir_read_n_i) && op_send_o != $past(dir_read_n_i)
    && ack_go_o == $past(dir_read_n_i)) else $error("byte move wrong");
  no_cmd_a :
  assert property (s_cmd(CMD_NONE) |=> !op_restart_o && !op_stop_o && !op_read_o && !op_send_o)
    else $error("empty command acted");
  flush_pulse_a :
  assert property (wr_i && addr_i == ADDR_CTRL_COMMAND && wdata_i[FLUSH_BIT] |=> flush_o ##1 !flush_o)
    else $error("flush strobe not one cycle");
  smart_ack_a :
  assert property (rd_i && addr_i == ADDR_BYTE && go && ctl_sh[AUTO_ACK_BIT] |=> ack_go_o)
    else $error("auto ack missing");
  read_gate_a :
  assert property (read_irq_o |-> ctl_sh[READ_IE_BIT]) else $error("read request while disabled");
  read_set_a :
  assert property (byte_read_done_i && go && ctl_sh[READ_IE_BIT] |=> read_irq_o)
    else $error("read request missing");
  write_gate_a :
  assert property (write_irq_o |-> ctl_sh[WRITE_IE_BIT]) else $error("write request while disabled");
  halt_level_a :
  assert property (halt_o == (debug_halt_i && !dbg_sh)) else $error("halt level wrong");
  halt_freeze_a :
  assert property (halt_o && !read_irq_o && !wr_i |=> !read_irq_o) else $error("event taken while halted");
  enable_bit_a :
  assert property (wr_i && addr_i == ADDR_CTRL_PRIMARY |=> master_enable_o == $past(wdata_i[0]))
    else $error("enable wrong");
  fast_plus_a :
  assert property (wr_i && addr_i == ADDR_CTRL_GLOBAL |=> fast_plus_o == $past(wdata_i[1]))
    else $error("fast plus wrong");
  cmd_zero_a :
  assert property (rd_i && addr_i == ADDR_CTRL_COMMAND |=> rdata_o[1:0] == 2'h0)
    else $error("command field reads nonzero");
endmodule : two_wire_master_chk
`default_nettype wire

// file: verification/bus_line_model.sv
`timescale 1ns/10ps
`default_nettype none
// far-side bus lines; both rest high as with pull-ups
module bus_line_model
(
  // serial lines
  output var logic scl_o,
  output var logic sda_o
);
  // lines released at time zero
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // start: data falls under high clock, then clock parks low
  task automatic start_c();
    sda_o = 1'b0;
    #80;
    scl_o = 1'b0;
    #80;
  endtask : start_c
  // stop: clock rises first, data rises while clock is high
  task automatic stop_c();
    scl_o = 1'b1;
    #80;
    sda_o = 1'b1;
    #80;
  endtask : stop_c
endmodule : bus_line_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// count a comparison; a mismatch prints one line
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top
  import two_wire_master_pkg::*;
;
  // stimulus, all given at time zero
  logic       core_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, debug_halt_i = 1'b0;
  logic       engine_owns_i = 1'b0, addr_ack_i = 1'b0, dir_read_n_i = 1'b0, scl_hold_set_i = 1'b0;
  logic       byte_read_done_i = 1'b0, byte_write_done_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rx_byte_i = 8'h00;
  // observed
  logic [7:0] rdata_o, target_o, byte_o;
  logic       master_enable_o, fast_plus_o, halt_o, flush_o, ack_go_o, ack_nack_o, addr_go_o, byte_go_o;
  logic       op_restart_o, op_read_o, op_send_o, op_stop_o, scl_release_o, read_irq_o, write_irq_o;
  wire logic  scl, sda;
  int         errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  always #10 core_clk_i = ~core_clk_i;

  bus_line_model lines (.scl_o(scl), .sda_o(sda));

  // short timeouts keep the run brief
  two_wire_master_control #(.TMO_50_CYC(20), .TMO_100_CYC(40), .TMO_200_CYC(80)) dut (
    .core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .debug_halt_i, .scl_i(scl), .sda_i(sda),
    .engine_owns_i, .addr_ack_i, .dir_read_n_i, .byte_read_done_i, .rx_byte_i, .byte_write_done_i,
    .scl_hold_set_i, .master_enable_o, .fast_plus_o, .halt_o, .flush_o, .addr_go_o, .byte_go_o, .ack_go_o,
    .ack_nack_o, .op_restart_o, .op_read_o, .op_send_o, .op_stop_o, .scl_release_o, .target_o, .byte_o,
    .read_irq_o, .write_irq_o);

  // one write; returns just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask : wr
  // one read; data stand from the following cycle on
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  // one engine event pulse: 0 read done, 1 write done, 2 address ack, 3 clock held
  task automatic ev(input int k, input logic [7:0] rx, input logic dr);
    @(posedge core_clk_i);
    byte_read_done_i  <= (k == 0);
    byte_write_done_i <= (k == 1);
    addr_ack_i        <= (k == 2);
    scl_hold_set_i    <= (k == 3);
    rx_byte_i         <= rx;
    dir_read_n_i      <= dr;
    @(posedge core_clk_i);
    {byte_read_done_i, byte_write_done_i, addr_ack_i, scl_hold_set_i} <= 4'h0;
    #1;
  endtask : ev

  // reset values and an unmapped place
  task automatic t_regs();
    logic [7:0] d;
    rd(ADDR_DEBUG, d);
    `CHK("debug", 8'h00, d)
    rd(ADDR_CTRL_COMMAND, d);
    `CHK("command reg", 8'h00, d)
    rd(ADDR_STATUS, d);
    `CHK("line state", LINE_UNKNOWN, d[1:0])
    rd(8'h01, d);
    `CHK("unmapped", 8'h00, d)
    $display("regs done");
  endtask : t_regs

  // speed select and enable
  task automatic t_cfg();
    logic [7:0] d;
    wr(ADDR_CTRL_GLOBAL, 8'h02);
    `CHK("fast plus on", 1'b1, fast_plus_o)
    wr(ADDR_CTRL_GLOBAL, 8'h00);
    `CHK("fast plus off", 1'b0, fast_plus_o)
    wr(ADDR_CTRL_PRIMARY, 8'h01);
    `CHK("enable", 1'b1, master_enable_o)
    rd(ADDR_CTRL_PRIMARY, d);
    `CHK("primary", 8'h01, d)
    $display("cfg done");
  endtask : t_cfg

  // all commands, both ack choices; 4 is byte move reading
  task automatic t_cmds();
    logic [7:0] d;
    ev(3, 8'h00, 1'b0);
    rd(ADDR_STATUS, d);
    `CHK("hold set", 1'b1, d[HOLD_BIT])
    for (int a = 0; a < 2; a++)
      for (int c = 0; c < 5; c++)
      begin
        @(posedge core_clk_i);
        dir_read_n_i <= (c == 4);
        wr(ADDR_CTRL_COMMAND, {5'h00, a[0], (c == 4) ? 2'h2 : c[1:0]});
        `CHK("restart", c == 1, op_restart_o)
        `CHK("send", c == 2, op_send_o)
        `CHK("read", c == 4, op_read_o)
        `CHK("stop", c == 3, op_stop_o)
        `CHK("ack go", c == 1 || c >= 3, ack_go_o)
        `CHK("release", c != 0, scl_release_o)
        if (c == 1 || c >= 3)
          `CHK("ack kind", a[0], ack_nack_o)
      end
    rd(ADDR_CTRL_COMMAND, d);
    `CHK("cmd readback", 8'h04, d)
    rd(ADDR_STATUS, d);
    `CHK("hold cleared", 1'b0, d[HOLD_BIT])
    wr(ADDR_CTRL_COMMAND, 8'h00);
    $display("cmds done");
  endtask : t_cmds

  // request gating by enables, clearing by status write
  task automatic t_irq();
    wr(ADDR_CTRL_PRIMARY, 8'h41);
    ev(0, 8'hA5, 1'b0);
    `CHK("byte in", 8'hA5, byte_o)
    `CHK("read irq masked", 1'b0, read_irq_o)
    wr(ADDR_CTRL_PRIMARY, 8'hC1);
    `CHK("read irq", 1'b1, read_irq_o)
    wr(ADDR_STATUS, 8'h80);
    `CHK("read irq clear", 1'b0, read_irq_o)
    ev(1, 8'h00, 1'b0);
    `CHK("write irq", 1'b1, write_irq_o)
    wr(ADDR_STATUS, 8'h40);
    `CHK("write irq clear", 1'b0, write_irq_o)
    $display("irq done");
  endtask : t_irq

  // quick command off and on, software stops after the quick read, then a quick write
  task automatic t_quick();
    ev(2, 8'h00, 1'b1);
    `CHK("quick off", 1'b0, read_irq_o)
    wr(ADDR_CTRL_PRIMARY, 8'hD1);
    ev(2, 8'h00, 1'b1);
    `CHK("quick read flag", 1'b1, read_irq_o)
    `CHK("no byte moved", 8'hA5, byte_o)
    wr(ADDR_CTRL_COMMAND, {6'h00, CMD_STOP});
    `CHK("stop after quick", 1'b1, op_stop_o)
    `CHK("flag cleared", 1'b0, read_irq_o)
    ev(2, 8'h00, 1'b0);
    `CHK("quick write flag", 1'b1, write_irq_o)
    wr(ADDR_STATUS, 8'h40);
    $display("quick done");
  endtask : t_quick

  // auto ack on byte read, both ack choices, then off
  task automatic t_smart();
    logic [7:0] d;
    wr(ADDR_CTRL_PRIMARY, 8'h03);
    for (int a = 0; a < 2; a++)
    begin
      wr(ADDR_CTRL_COMMAND, {5'h00, a[0], 2'h0});
      rd(ADDR_BYTE, d);
      `CHK("auto ack", 1'b1, ack_go_o)
      `CHK("auto ack kind", a[0], ack_nack_o)
    end
    wr(ADDR_CTRL_PRIMARY, 8'h01);
    rd(ADDR_BYTE, d);
    `CHK("no auto ack", 1'b0, ack_go_o)
    wr(ADDR_CTRL_COMMAND, 8'h00);
    $display("smart done");
  endtask : t_smart

  // target before byte, then flush clears both
  task automatic t_flush();
    wr(ADDR_TARGET, 8'h5A);
    wr(ADDR_BYTE, 8'h3C);
    `CHK("byte reg", 8'h3C, byte_o)
    `CHK("byte go", 1'b1, byte_go_o)
    wr(ADDR_CTRL_COMMAND, 8'h00);
    `CHK("flush zero", 1'b0, flush_o)
    wr(ADDR_CTRL_COMMAND, 8'h08);
    `CHK("flush strobe", 1'b1, flush_o)
    @(posedge core_clk_i);
    #1;
    `CHK("flush one cycle", 1'b0, flush_o)
    `CHK("target cleared", 8'h00, target_o)
    `CHK("byte cleared", 8'h00, byte_o)
    `CHK("enable kept", 1'b1, master_enable_o)
    $display("flush done");
  endtask : t_flush

  // break halt freezes events and commands unless run bit set
  task automatic t_halt();
    wr(ADDR_CTRL_PRIMARY, 8'hC1);
    @(posedge core_clk_i);
    debug_halt_i <= 1'b1;
    #1;
    `CHK("halted", 1'b1, halt_o)
    ev(0, 8'h11, 1'b0);
    `CHK("event ignored", 1'b0, read_irq_o)
    wr(ADDR_CTRL_COMMAND, {6'h00, CMD_STOP});
    `CHK("cmd ignored", 1'b0, op_stop_o)
    wr(ADDR_DEBUG, 8'h01);
    `CHK("runs", 1'b0, halt_o)
    ev(0, 8'h11, 1'b0);
    `CHK("event taken", 1'b1, read_irq_o)
    wr(ADDR_STATUS, 8'h80);
    @(posedge core_clk_i);
    debug_halt_i <= 1'b0;
    $display("halt done");
  endtask : t_halt

  // line state and each timeout code
  task automatic t_tmo();
    logic [7:0] d;
    int         lim [4] = '{0, 20, 40, 80};
    lines.start_c();
    lines.stop_c();
    repeat (8) @(posedge core_clk_i);
    rd(ADDR_STATUS, d);
    `CHK("idle", LINE_IDLE, d[1:0])
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk_i);
      engine_owns_i <= (k == 3);
      wr(ADDR_CTRL_PRIMARY, {4'h0, k[1:0], 2'b01});
      lines.start_c();
      repeat ((k == 0) ? 60 : lim[k] / 2) @(posedge core_clk_i);
      rd(ADDR_STATUS, d);
      `CHK("busy", (k == 3) ? LINE_OWNER : LINE_BUSY, d[1:0])
      repeat ((k == 0) ? 60 : lim[k] / 2 + 12) @(posedge core_clk_i);
      rd(ADDR_STATUS, d);
      `CHK("after limit", (k == 0) ? LINE_BUSY : LINE_IDLE, d[1:0])
      lines.stop_c();
      repeat (8) @(posedge core_clk_i);
    end
    wr(ADDR_TARGET, 8'h21);
    `CHK("addr go", 1'b1, addr_go_o)
    wr(ADDR_CTRL_PRIMARY, 8'h00);
    rd(ADDR_STATUS, d);
    `CHK("disabled", LINE_UNKNOWN, d[1:0])
    $display("timeout done");
  endtask : t_tmo

  // counts, verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // hang guard, well above the expected run length
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      summarize();
    end
  end

  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_cfg();
    t_cmds();
    t_irq();
    t_quick();
    t_smart();
    t_flush();
    t_halt();
    t_tmo();
    summarize();
  end
endmodule : tb_top

bind two_wire_master_control two_wire_master_chk u_chk (
  .core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .debug_halt_i, .dir_read_n_i, .byte_read_done_i,
  .master_enable_o, .fast_plus_o, .halt_o, .flush_o, .ack_go_o, .ack_nack_o, .op_restart_o, .op_read_o,
  .op_send_o, .op_stop_o, .scl_release_o, .read_irq_o, .write_irq_o);
`default_nettype wire
